// ### fpbic_pkg.sv
// fpbic_pkg.sv: constants and types shared by the front-panel controller
// assumes a 25 MHz pclk and a synchronous single-clock system
package fpbic_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int LONG_MIN_MS = 1000;
  localparam int LONG_MAX_MS = 2000;
  localparam int EXT_MIN_MS = 5000;
  localparam int DEBOUNCE_US = 10_000;
  localparam int LONG_MIN_CYC = (LONG_MIN_MS * (CLK_HZ / 1000));
  localparam int LONG_MAX_CYC = (LONG_MAX_MS * (CLK_HZ / 1000));
  localparam int EXT_MIN_CYC = (EXT_MIN_MS * (CLK_HZ / 1000));
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam int SEC_CYC = CLK_HZ;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] POS_OFS = 12'h008;
  localparam logic [11:0] ICON_OFS = 12'h00C;
  localparam logic [11:0] EVT_OFS = 12'h010;
  localparam int CTRL_DIAG_EN_BIT = 0;
  localparam int CTRL_DIAG_CLR_BIT = 1;
  localparam int CTRL_LN_WIRING_BIT = 2;
  localparam int CTRL_BILLING_BIT = 3;
  localparam int CTRL_CLOCK_PAGE_BIT = 4;
  localparam int CTRL_SHORTCUT_BIT = 5;
  localparam int CTRL_TARIFF_POS = 8;
  localparam int CTRL_EDIT_BIT = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [3:0] NUM_DISPLAYS = 4'h9;
  localparam logic [7:0] NUM_PAGES = 8'h10;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    FPBIC_IDLE = 3'b000,
    FPBIC_SEL = 3'b001,
    FPBIC_ADV = 3'b010,
    FPBIC_BOTH = 3'b011,
    FPBIC_DONE = 3'b100
  } fpbic_btn_e;

  typedef enum logic [1:0] {
    FPBIC_DIAG_NONE = 2'b00,
    FPBIC_DIAG_BATT = 2'b01,
    FPBIC_DIAG_FIELD = 2'b10,
    FPBIC_DIAG_GEN = 2'b11
  } fpbic_diag_e;

  typedef enum logic [1:0] {
    FPBIC_PF_NOLOAD = 2'b00,
    FPBIC_PF_IMPORT = 2'b01,
    FPBIC_PF_EXPORT = 2'b10
  } fpbic_pf_e;

endpackage

// ### fpbic_top.sv
// fpbic_top.sv: button classifier, navigation and status icon driver
// assumes synchronous button levels (active high = pressed) and
// analog comparators already resolved to per-phase flags
//
// Overview of operation
// - press classed short, long 1 to 5 s, or extended 5 s and over
// - page-advance acts at press, not release
// - page-advance: next page in display, next item or digit in programming
// - select acts on release, extended hold in display mode at 5 s; action depends on hold time
// - display mode: select short next display, over 5 s enters programming
// - programming: select short next item, one second hold selects item
// - both short in display mode returns to start page
// - both over 5 s on chosen pages jumps to page menu
// - both short on clock page toggles test display
// - position shown as display, page and item numbers
// - tariff icon shown only on billing displays
// - diagnostic active: tariff position alternates with diagnostic icon
// - diagnostic icon held steady; only the highest priority one is shown
// - priority battery over field over general messages
// - battery icon follows low battery condition itself
// - field icon self clears; start and end events logged
// - general icon stays until cleared by control write or reset; can be disabled
// - power-flow icon: no load, import, export
// - phase indicators use wiring-selected voltage set
// - phase steady above dip, blinks below dip
// - phase below interruption shows a dash
// - refresh once per second, clock page twice per second
`timescale 1ns/10ps
`default_nettype none
module fpbic_top #(
  parameter int LONG_MIN = fpbic_pkg::LONG_MIN_CYC,
  parameter int LONG_MAX = fpbic_pkg::LONG_MAX_CYC,
  parameter int EXT_MIN = fpbic_pkg::EXT_MIN_CYC,
  parameter int DEBOUNCE = fpbic_pkg::DEBOUNCE_CYC,
  parameter int SEC = fpbic_pkg::SEC_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_adv,
  input wire logic btn_sel,
  input wire logic batt_low,
  input wire logic field_high,
  input wire logic diag_msg,
  input wire logic [1:0] power_flow,
  input wire logic [2:0] line_to_neutral_voltages_dip,
  input wire logic [2:0] line_to_neutral_voltages_intr,
  input wire logic [2:0] line_to_line_voltages_dip,
  input wire logic [2:0] line_to_line_voltages_intr,
  output logic prog_mode,
  output logic test_display,
  output logic [3:0] disp_num,
  output logic [7:0] page_num,
  output logic [7:0] item_num,
  output logic digit_step,
  output logic item_select,
  output logic shortcut_menu,
  output logic refresh,
  output logic [7:0] tariff_icons,
  output logic [1:0] diag_icon,
  output logic [1:0] pf_icon,
  output logic [2:0] phase_on,
  output logic [2:0] phase_dash,
  output logic field_evt
);
  import fpbic_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] adv_sy;
    logic [1:0] sel_sy;
    logic adv_db;
    logic sel_db;
    logic [31:0] adv_cnt;
    logic [31:0] sel_cnt;
    fpbic_btn_e btn;
    logic [31:0] hold;
    logic ext_done;
    logic prog;
    logic test;
    logic [3:0] disp;
    logic [7:0] page;
    logic [7:0] item;
    logic digit;
    logic sel_item;
    logic shortcut;
    logic [31:0] sec_cnt;
    logic half;
    logic refresh;
    logic [31:0] ctrl;
    logic gen_diag;
    logic field_prev;
    logic field_evt;
    logic [1:0] field_log;
    logic [31:0] prdata;
    logic [7:0] tariff;
    logic [1:0] diag;
    logic [1:0] pf;
    logic [2:0] ph_on;
    logic [2:0] ph_dash;
  } fpbic_state_s;

  fpbic_state_s s_q, s_d;
  logic [2:0] dip_sel, intr_sel;
  logic acc_wr, acc_rd, edit_mode;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && !penable && !pwrite;
  assign edit_mode = s_q.ctrl[CTRL_EDIT_BIT];

  always_comb begin
    s_d = s_q;
    s_d.digit = 1'b0;
    s_d.sel_item = 1'b0;
    s_d.shortcut = 1'b0;
    s_d.refresh = 1'b0;
    s_d.field_evt = 1'b0;
    dip_sel = 3'b000;
    intr_sel = 3'b000;

    // ****************************************
    // debounce
    // ****************************************
    s_d.adv_sy = {s_q.adv_sy[0], btn_adv};
    s_d.sel_sy = {s_q.sel_sy[0], btn_sel};
    if (s_q.adv_sy[1] == s_q.adv_db) begin
      s_d.adv_cnt = 32'h0000_0000;
    end else if (s_q.adv_cnt >= DEBOUNCE - 1) begin
      s_d.adv_db = s_q.adv_sy[1];
      s_d.adv_cnt = 32'h0000_0000;
    end else begin
      s_d.adv_cnt = s_q.adv_cnt + 32'h0000_0001;
    end
    if (s_q.sel_sy[1] == s_q.sel_db) begin
      s_d.sel_cnt = 32'h0000_0000;
    end else if (s_q.sel_cnt >= DEBOUNCE - 1) begin
      s_d.sel_db = s_q.sel_sy[1];
      s_d.sel_cnt = 32'h0000_0000;
    end else begin
      s_d.sel_cnt = s_q.sel_cnt + 32'h0000_0001;
    end

    // ****************************************
    // press classification and navigation
    // ****************************************
    if (s_q.hold != 32'hFFFF_FFFF) begin
      s_d.hold = s_q.hold + 32'h0000_0001;
    end
    case (s_q.btn)
      FPBIC_IDLE: begin
        s_d.hold = 32'h0000_0000;
        s_d.ext_done = 1'b0;
        if (s_q.adv_db && s_q.sel_db) begin
          s_d.btn = FPBIC_BOTH;
        end else if (s_q.sel_db) begin
          s_d.btn = FPBIC_SEL;
        end else if (s_q.adv_db) begin
          s_d.btn = FPBIC_ADV;
          if (!s_q.prog) begin
            s_d.page = (s_q.page == NUM_PAGES - 8'h01) ? 8'h00 :
              s_q.page + 8'h01;
          end else if (edit_mode) begin
            s_d.digit = 1'b1;
          end else begin
            s_d.item = s_q.item + 8'h01;
          end
        end
      end
      FPBIC_ADV: begin
        if (s_q.sel_db) begin
          s_d.btn = FPBIC_BOTH;
        end else if (!s_q.adv_db) begin
          s_d.btn = FPBIC_IDLE;
        end
      end
      FPBIC_SEL: begin
        if (s_q.adv_db) begin
          s_d.btn = FPBIC_BOTH;
        end else if (!s_q.prog && s_q.hold >= EXT_MIN && !s_q.ext_done) begin
          s_d.prog = 1'b1;
          s_d.item = 8'h00;
          s_d.ext_done = 1'b1;
        end else if (!s_q.sel_db) begin
          s_d.btn = FPBIC_IDLE;
          if (s_q.ext_done) begin
            s_d.btn = FPBIC_IDLE;
          end else if (s_q.hold < LONG_MIN) begin
            if (!s_q.prog) begin
              s_d.disp = (s_q.disp == NUM_DISPLAYS) ? 4'h1 :
                s_q.disp + 4'h1;
              s_d.page = 8'h00;
            end else begin
              s_d.item = s_q.item + 8'h01;
            end
          end else if (s_q.prog) begin
            // 2 to 5 s also long
            s_d.sel_item = 1'b1;
          end
        end
      end
      FPBIC_BOTH: begin
        if (!s_q.prog && s_q.hold >= EXT_MIN && !s_q.ext_done &&
            s_q.ctrl[CTRL_SHORTCUT_BIT]) begin
          s_d.shortcut = 1'b1;
          s_d.prog = 1'b1;
          s_d.ext_done = 1'b1;
        end
        if (!s_q.adv_db && !s_q.sel_db) begin
          s_d.btn = FPBIC_IDLE;
          if (!s_q.prog && !s_q.ext_done && s_q.hold < LONG_MIN) begin
            if (s_q.ctrl[CTRL_CLOCK_PAGE_BIT]) begin
              s_d.test = !s_q.test;
            end else begin
              s_d.page = 8'h00;
            end
          end
        end
      end
      default: s_d.btn = FPBIC_IDLE;
    endcase

    // ****************************************
    // registers
    // ****************************************
    if (acc_wr) begin
      case (paddr)
        CTRL_OFS: s_d.ctrl = pwdata;
        POS_OFS: s_d.prog = pwdata[0];
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    if (acc_rd) begin
      case (paddr)
        CTRL_OFS: s_d.prdata = s_q.ctrl;
        STAT_OFS: s_d.prdata = {27'h000_0000, s_q.btn, s_q.prog, s_q.test};
        POS_OFS: s_d.prdata = {12'h000, s_q.disp, s_q.page, s_q.item};
        ICON_OFS: s_d.prdata = {14'h0000, s_q.ph_dash, s_q.ph_on, s_q.pf,
          s_q.diag, s_q.tariff};
        EVT_OFS: s_d.prdata = {30'h0000_0000, s_q.field_log};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // ****************************************
    // refresh timebase
    // ****************************************
    // 1 Hz, 2 Hz on clock page
    if (s_q.sec_cnt >= SEC / 2 - 1) begin
      s_d.sec_cnt = 32'h0000_0000;
      s_d.half = !s_q.half;
      s_d.refresh = s_q.half || s_q.ctrl[CTRL_CLOCK_PAGE_BIT];
    end else begin
      s_d.sec_cnt = s_q.sec_cnt + 32'h0000_0001;
    end

    // ****************************************
    // icons
    // ****************************************
    // sticky until cleared; set wins
    if (diag_msg) begin
      s_d.gen_diag = 1'b1;
    end else if (acc_wr && paddr == CTRL_OFS && pwdata[CTRL_DIAG_CLR_BIT]) begin
      s_d.gen_diag = 1'b0;
    end
    s_d.field_prev = field_high;
    if (field_high != s_q.field_prev) begin
      s_d.field_evt = 1'b1;
      s_d.field_log = {field_high, !field_high};
    end
    if (batt_low) begin
      s_d.diag = FPBIC_DIAG_BATT;
    end else if (field_high) begin
      s_d.diag = FPBIC_DIAG_FIELD;
    end else if (s_q.gen_diag && s_q.ctrl[CTRL_DIAG_EN_BIT]) begin
      s_d.diag = FPBIC_DIAG_GEN;
    end else begin
      s_d.diag = FPBIC_DIAG_NONE;
    end
    s_d.tariff = 8'h00;
    if (s_q.ctrl[CTRL_BILLING_BIT] && !(s_q.diag != FPBIC_DIAG_NONE &&
        s_q.half)) begin
      s_d.tariff[s_q.ctrl[CTRL_TARIFF_POS +: 3]] = 1'b1;
    end
    s_d.pf = (power_flow == 2'b11) ? FPBIC_PF_NOLOAD : power_flow;
    dip_sel = s_q.ctrl[CTRL_LN_WIRING_BIT] ?
      line_to_neutral_voltages_dip : line_to_line_voltages_dip;
    intr_sel = s_q.ctrl[CTRL_LN_WIRING_BIT] ?
      line_to_neutral_voltages_intr : line_to_line_voltages_intr;
    s_d.ph_dash = intr_sel;
    s_d.ph_on = ~intr_sel & ~(dip_sel & {3{s_q.half}});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.disp <= 4'h1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // position numbers out
  assign disp_num = s_q.disp;
  assign page_num = s_q.page;
  assign item_num = s_q.item;
  assign prog_mode = s_q.prog;
  assign test_display = s_q.test;
  assign digit_step = s_q.digit;
  assign item_select = s_q.sel_item;
  assign shortcut_menu = s_q.shortcut;
  assign refresh = s_q.refresh;
  assign tariff_icons = s_q.tariff;
  assign diag_icon = s_q.diag;
  assign pf_icon = s_q.pf;
  assign phase_on = s_q.ph_on;
  assign phase_dash = s_q.ph_dash;
  assign field_evt = s_q.field_evt;
  assign prdata = s_q.prdata;

  // ****************************************
  // checks
  // ****************************************
  a_battery_first: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && batt_low |=> diag_icon == FPBIC_DIAG_BATT)
    else $error("battery not highest priority");
  a_field_over_gen: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !batt_low && field_high |=> diag_icon == FPBIC_DIAG_FIELD)
    else $error("field icon missing");
  a_dash_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (phase_dash & phase_on) == 3'b000)
    else $error("dashed phase also lit");
  a_tariff_billing: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !s_q.ctrl[CTRL_BILLING_BIT] |=> tariff_icons == 8'h00)
    else $error("tariff shown off billing");
  a_tariff_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(tariff_icons))
    else $error("more than one tariff icon");
  a_gen_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && diag_msg |=> s_q.gen_diag)
    else $error("general diagnostic lost");
  a_pf_legal: assert property (@(posedge pclk) disable iff (!presetn)
    pf_icon != 2'b11)
    else $error("illegal power flow icon");
  a_ext_prog: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.btn == FPBIC_SEL && !s_q.prog && !s_q.adv_db &&
    s_q.hold >= EXT_MIN && !s_q.ext_done |=> prog_mode)
    else $error("extended select missed programming");
  a_disp_range: assert property (@(posedge pclk) disable iff (!presetn)
    disp_num >= 4'h1 && disp_num <= NUM_DISPLAYS)
    else $error("display number out of range");
endmodule
`default_nettype wire

// ### fpbic_operator.sv
// fpbic_operator.sv: behavioural operator pressing the two panel buttons
// assumes the bench calls push and let_go; buttons are high when pressed
`timescale 1ns/10ps
`default_nettype none
module fpbic_operator (
  input wire logic pclk,
  output logic btn_adv,
  output logic btn_sel
);
  initial begin
    btn_adv = 1'b0;
    btn_sel = 1'b0;
  end
  // m bit0 page-advance, bit1 select
  task automatic drive(input logic [1:0] m, input logic v);
    @(posedge pclk);
    {btn_sel, btn_adv} <= ({btn_sel, btn_adv} & ~m) | (m & {2{v}});
  endtask
  // contact bounce on both edges
  // one-cycle chatter, shorter than debounce, must never count twice
  task automatic push(input logic [1:0] m);
    drive(m, 1'b1);
    drive(m, 1'b0);
    drive(m, 1'b1);
  endtask
  task automatic let_go(input logic [1:0] m);
    drive(m, 1'b0);
    drive(m, 1'b1);
    drive(m, 1'b0);
  endtask
endmodule
`default_nettype wire

// ### fpbic_top_test.sv
// fpbic_top_test.sv: self-checking bench for the panel controller
// assumes shortened timing parameters and the operator model
`timescale 1ns/10ps
`default_nettype none
module fpbic_top_test;
  import fpbic_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic btn_adv, btn_sel, batt_low, field_high, diag_msg, clk_en;
  logic prog_mode, test_display, digit_step, item_select;
  logic shortcut_menu, refresh, field_evt;
  logic [1:0] power_flow, diag_icon, pf_icon;
  logic [2:0] ln_dip, ln_intr, ll_dip, ll_intr;
  logic [2:0] phase_on, phase_dash, por, pand;
  logic [3:0] disp_num, seen;
  logic [7:0] page_num, item_num, tariff_icons, tor, tand;
  int failures, comparisons, n_item, n_cut, n_dig, n_ref, n_evt;
  fpbic_top #(.LONG_MIN(20), .LONG_MAX(40), .EXT_MIN(100),
    .DEBOUNCE(4), .SEC(16)) dut_u (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .btn_adv,
    .btn_sel, .batt_low, .field_high, .diag_msg, .power_flow,
    .line_to_neutral_voltages_dip(ln_dip),
    .line_to_neutral_voltages_intr(ln_intr),
    .line_to_line_voltages_dip(ll_dip),
    .line_to_line_voltages_intr(ll_intr),
    .prog_mode, .test_display, .disp_num, .page_num, .item_num,
    .digit_step, .item_select, .shortcut_menu, .refresh,
    .tariff_icons, .diag_icon, .pf_icon, .phase_on, .phase_dash,
    .field_evt
  );
  fpbic_operator op_u (.pclk, .btn_adv, .btn_sel);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_item += int'(item_select === 1'b1);
    n_cut += int'(shortcut_menu === 1'b1);
    n_dig += int'(digit_step === 1'b1);
    n_ref += int'(refresh === 1'b1);
    n_evt += int'(field_evt === 1'b1);
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string w, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; read data lands in rd
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) check("pready", pready, 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic press(input logic [1:0] m, input int hold);
    op_u.push(m);
    tick(hold);
    op_u.let_go(m);
    tick(12);
  endtask
  // collects icons over n cycles, after two to settle
  task automatic watch(input int n);
    tick(2);
    seen = '0;
    {tor, por} = '0;
    {tand, pand} = '1;
    repeat (n) begin
      @(posedge pclk);
      seen[diag_icon] = 1'b1;
      tor |= tariff_icons;
      tand &= tariff_icons;
      por |= phase_on;
      pand &= phase_on;
    end
  endtask
  // diag levels {batt, field, msg}; {ln dip, ln intr, ll dip, ll intr}
  task automatic levels(input logic [2:0] d, input logic [11:0] v);
    {batt_low, field_high, diag_msg} <= d;
    {ln_dip, ln_intr, ll_dip, ll_intr} <= v;
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    tick(12);
    presetn <= 1'b1;
    tick(1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_buttons;
    check("disp", disp_num, 4'h1);
    apb(1'b1, 12'h100, 32'hffff_ffff);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    check("ctrl", rd, CTRL_RST);
    op_u.push(2'b01);
    tick(12);
    check("page held", page_num, 8'h01);
    op_u.let_go(2'b01);
    tick(12);
    check("page", page_num, 8'h01);
    check("disp adv", disp_num, 4'h1);
    press(2'b11, 8);
    check("start page", page_num, 8'h00);
    op_u.push(2'b10);
    tick(8);
    check("disp held", disp_num, 4'h1);
    op_u.let_go(2'b10);
    tick(12);
    check("disp next", disp_num, 4'h2);
    apb(1'b0, POS_OFS, 32'h0000_0000);
    check("pos", rd, 32'h0002_0000);
    $display("t_buttons done");
  endtask
  task automatic t_special;
    int n0;
    apb(1'b1, CTRL_OFS, 32'h0000_0011);
    press(2'b11, 8);
    check("test on", test_display, 1'b1);
    n0 = n_ref;
    tick(64);
    check("fast refresh", (n_ref - n0) inside {[7:9]}, 1'b1);
    press(2'b11, 8);
    check("test off", test_display, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0000_0021);
    n0 = n_ref;
    tick(64);
    check("refresh", (n_ref - n0) inside {[3:5]}, 1'b1);
    n0 = n_cut;
    press(2'b11, 110);
    check("shortcut", n_cut - n0, 1);
    $display("t_special done");
  endtask
  task automatic t_prog;
    int n0;
    logic [7:0] p, i;
    op_u.push(2'b10);
    tick(110);
    check("prog held", prog_mode, 1'b1);
    op_u.let_go(2'b10);
    tick(12);
    check("no short after ext", disp_num, 4'h1);
    n0 = n_item;
    press(2'b10, 25);
    check("select long", n_item - n0, 1);
    i = item_num;
    press(2'b10, 5);
    check("item moved", item_num !== i, 1'b1);
    check("no select", n_item - n0, 1);
    p = page_num;
    i = item_num;
    press(2'b01, 5);
    check("page kept", page_num, p);
    check("item adv", item_num !== i, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0000_8001);
    n0 = n_dig;
    press(2'b01, 5);
    check("digit", n_dig - n0, 1);
    $display("t_prog done");
  endtask
  task automatic t_diag;
    int n0;
    n0 = n_evt;
    levels(3'b111, 12'h000);
    watch(64);
    check("batt first", seen[3:1], 3'b001);
    levels(3'b011, 12'h000);
    watch(64);
    check("field next", seen[3:1], 3'b010);
    levels(3'b000, 12'h000);
    watch(64);
    check("general", seen[3:1], 3'b100);
    check("field log", n_evt - n0, 2);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    watch(64);
    check("cleared", seen[3:1], 3'b000);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    levels(3'b001, 12'h000);
    watch(64);
    check("disabled", seen[3:1], 3'b000);
    levels(3'b000, 12'h000);
    $display("t_diag done");
  endtask
  task automatic t_icons;
    logic [15:0] pos;
    // clear the pending general icon so tariff stands steady
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, CTRL_OFS, 32'h0000_000A | (k << 8));
      tick(4);
      check("tariff", tariff_icons, 8'h01 << k);
    end
    levels(3'b100, 12'h000);
    watch(64);
    check("alternate", {tor, tand}, 16'h8000);
    levels(3'b000, 12'h000);
    apb(1'b1, CTRL_OFS, 32'h0000_0005);
    watch(8);
    check("no billing", tor, 8'h00);
    for (int k = 0; k < 4; k++) begin
      power_flow <= k[1:0];
      tick(4);
      check("flow", pf_icon, (k == 3) ? 2'b00 : k[1:0]);
    end
    levels(3'b000, 12'h680);
    watch(64);
    check("dash", phase_dash, 3'b010);
    check("blink", {por, pand}, 6'b101_100);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    tick(4);
    check("line set", {phase_on, phase_dash}, 6'b111_000);
    levels(3'b000, 12'h00C);
    watch(64);
    check("line dash", phase_dash, 3'b100);
    check("line blink", {por, pand}, 6'b011_010);
    // clock enable low: a full press must move nothing
    clk_en <= 1'b0;
    pos = {page_num, item_num};
    op_u.push(2'b01);
    tick(12);
    op_u.let_go(2'b01);
    tick(12);
    check("frozen", {page_num, item_num}, pos);
    clk_en <= 1'b1;
    tick(12);
    $display("t_icons done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    power_flow = 2'b00;
    clk_en = 1'b1;
    levels(3'b000, 12'h000);
    {n_item, n_cut, n_dig, n_ref, n_evt} = '0;
    failures = 0;
    comparisons = 0;
    presetn = 1'b0;
    tick(12);
    presetn <= 1'b1;
    tick(1);
    t_buttons;
    t_special;
    do_reset;
    t_prog;
    t_diag;
    t_icons;
    end_of_test;
  end
endmodule
`default_nettype wire
